/* File: hdl/stdc_regs.vh */
// register map and reset values of the tick down counter
`ifndef STDC_REGS_VH
`define STDC_REGS_VH

// ***************************************************************
// byte offsets
// ***************************************************************
`define STDC_OFS_CTRL       8'h00
`define STDC_OFS_RELOAD     8'h04
`define STDC_OFS_CURRENT    8'h08
`define STDC_OFS_IRQ_STAT   8'h0C
`define STDC_OFS_IRQ_CLR    8'h10
`define STDC_OFS_IRQ_EN     8'h14

// ***************************************************************
// fields
// ***************************************************************
`define STDC_CTRL_EN_BIT    0
`define STDC_CTRL_WRAP_BIT  16
`define STDC_CNT_W          24
`define STDC_EVT_WRAP_BIT   0
`define STDC_EVT_HALT_BIT   1
`define STDC_EVT_N          2

// ***************************************************************
// reset values and answers
// ***************************************************************
`define STDC_RST_EN         1'h0
`define STDC_RST_RELOAD     24'h000000
`define STDC_RST_FLAG       1'h0
`define STDC_RST_EVT        2'h0
`define STDC_RESP_OKAY      2'h0
`define STDC_RESP_SLVERR    2'h2

`endif

/* File: hdl/stdc_axil_slave.v */
// axi4-lite slave front end turning bus beats into register strobes
`include "stdc_regs.vh"

module stdc_axil_slave #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  output wire          wr_en,
  output wire [AW-1:0] wr_addr,
  output wire [31:0]   wr_data,
  output wire [3:0]    wr_strb,
  input  wire          wr_err,
  output wire          rd_en,
  output wire [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_err
);
  reg          aw_full_ff;
  reg          w_full_ff;
  reg [AW-1:0] awaddr_ff;
  reg [31:0]   wdata_ff;
  reg [3:0]    wstrb_ff;
  reg          bvalid_ff;
  reg [1:0]    bresp_ff;
  reg          rvalid_ff;
  reg [1:0]    rresp_ff;
  reg [31:0]   rdata_ff;

  assign s_axi_awready = ~aw_full_ff;
  assign s_axi_wready  = ~w_full_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // write fires once both halves are held and the old answer is gone
  assign wr_en   = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign rd_en   = s_axi_arvalid & ~rvalid_ff;
  assign rd_addr = s_axi_araddr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awaddr_ff  <= {AW{1'b0}};
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `STDC_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `STDC_RESP_OKAY;
      rdata_ff   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && !aw_full_ff) begin
        aw_full_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_full_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_ff) begin
        w_full_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (wr_en) begin
        w_full_ff <= 1'b0;
      end
      if (wr_en) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_err ? `STDC_RESP_SLVERR : `STDC_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_en) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_data;
        rresp_ff  <= rd_err ? `STDC_RESP_SLVERR : `STDC_RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule

/* File: hdl/stdc_irq.v */
// sticky event status with enable mask and write-one-to-clear
module stdc_irq #(
  parameter N = 2
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [N-1:0] evt,
  input  wire         clr_wr,
  input  wire [N-1:0] clr_data,
  input  wire         en_wr,
  input  wire [N-1:0] en_data,
  output wire [N-1:0] status,
  output wire [N-1:0] enable,
  output wire         irq
);
  reg  [N-1:0] status_ff;
  reg  [N-1:0] enable_ff;
  wire [N-1:0] nxt_status;

  // a new event beats a clear landing in the same cycle
  assign nxt_status = (status_ff & ~(clr_wr ? clr_data : {N{1'b0}}))
                      | evt;
  assign status = status_ff;
  assign enable = enable_ff;
  assign irq    = |(status_ff & enable_ff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= {N{1'b0}};
      enable_ff <= {N{1'b0}};
    end else begin
      status_ff <= nxt_status;
      if (en_wr) begin
        enable_ff <= en_data;
      end
    end
  end
endmodule

/* File: hdl/stdc_top.v */
// 24-bit periodic tick down counter with axi4-lite register access
//
// Operation
// - The count is a 24-bit down counter that wraps at zero, and any write to its current-value register clears it to zero.
// - While enabled, the count drops by one each clock from its present value down to zero.
// - One clock after the count reaches zero it reloads from the reload-value register and then keeps counting down.
// - The wrap flag is set whenever counting brings the count to zero.
// - The current value is not defined after reset until software writes it.
// - With a reload value of zero the count stays at zero after the reload, even while enabled.
`include "stdc_regs.vh"

module stdc_top #(
  parameter AW    = 8,
  parameter CNT_W = `STDC_CNT_W
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [AW-1:0]    s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output wire [1:0]       s_axi_bresp,
  output wire             s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [AW-1:0]    s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output wire [31:0]      s_axi_rdata,
  output wire [1:0]       s_axi_rresp,
  output wire             s_axi_rvalid,
  input  wire             s_axi_rready,
  output wire [CNT_W-1:0] tick_current_value,
  output wire             tick_wrap_flag,
  output wire             irq
);

  // ***************************************************************
  // register selects
  // ***************************************************************
  localparam SEL_CTRL = 6'h01;
  localparam SEL_RLD  = 6'h02;
  localparam SEL_CUR  = 6'h04;
  localparam SEL_IST  = 6'h08;
  localparam SEL_ICLR = 6'h10;
  localparam SEL_IEN  = 6'h20;
  localparam SEL_NONE = 6'h00;

  // one-hot select of a word address, zero when unmapped
  function [5:0] reg_sel;
    input [AW-1:0] addr;
    begin
      case (addr[7:0])
        `STDC_OFS_CTRL:     reg_sel = SEL_CTRL;
        `STDC_OFS_RELOAD:   reg_sel = SEL_RLD;
        `STDC_OFS_CURRENT:  reg_sel = SEL_CUR;
        `STDC_OFS_IRQ_STAT: reg_sel = SEL_IST;
        `STDC_OFS_IRQ_CLR:  reg_sel = SEL_ICLR;
        `STDC_OFS_IRQ_EN:   reg_sel = SEL_IEN;
        default:            reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ***************************************************************
  // bus front end
  // ***************************************************************
  wire          wr_en;
  wire [AW-1:0] wr_addr;
  wire [31:0]   wr_data;
  wire [3:0]    wr_strb;
  wire          wr_err;
  wire          rd_en;
  wire [AW-1:0] rd_addr;
  reg  [31:0]   rd_data;
  wire          rd_err;
  wire [5:0]    wsel;
  wire [5:0]    rsel;

  stdc_axil_slave #(
    .AW (AW)
  ) u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  assign wsel   = reg_sel(wr_addr);
  assign rsel   = reg_sel(rd_addr);
  assign wr_err = (wsel == SEL_NONE);
  assign rd_err = (rsel == SEL_NONE);

  // ***************************************************************
  // control and reload registers
  // ***************************************************************
  reg              enable_ff;
  reg              nxt_enable;
  reg  [CNT_W-1:0] reload_ff;
  reg  [CNT_W-1:0] nxt_reload;
  wire [31:0]      reload_word;
  wire [31:0]      reload_merged;

  assign reload_word = {{(32 - CNT_W){1'b0}}, reload_ff};

  // byte lanes merge under wstrb, untouched lanes keep old data
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign reload_merged[lane*8 +: 8] = wr_strb[lane]
        ? wr_data[lane*8 +: 8] : reload_word[lane*8 +: 8];
    end
  endgenerate

  always @* begin
    nxt_reload = reload_ff;
    nxt_enable = enable_ff;
    if (wr_en && wsel == SEL_RLD) begin
      nxt_reload = reload_merged[CNT_W-1:0];
    end
    // enable lives in the low byte lane only
    if (wr_en && wsel == SEL_CTRL && wr_strb[0]) begin
      nxt_enable = wr_data[`STDC_CTRL_EN_BIT];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_ff <= `STDC_RST_EN;
      reload_ff <= `STDC_RST_RELOAD;
    end else begin
      enable_ff <= nxt_enable;
      reload_ff <= nxt_reload;
    end
  end

  // ***************************************************************
  // down counter
  // ***************************************************************
  reg  [CNT_W-1:0] count_ff;
  reg  [CNT_W-1:0] nxt_count;
  wire             count_zero;
  wire             cur_wr;
  reg              wrap_evt;
  reg              halt_evt;

  assign count_zero = (count_ff == {CNT_W{1'b0}});
  assign cur_wr     = wr_en & (wsel == SEL_CUR);

  always @* begin
    nxt_count = count_ff;
    wrap_evt  = 1'b0;
    halt_evt  = 1'b0;
    if (cur_wr) begin
      // a cleared count never raises the wrap flag
      // any data clears
      nxt_count = {CNT_W{1'b0}};
    end else if (enable_ff) begin
      if (count_zero) begin
        nxt_count = reload_ff;
        // status bit1 tells software that counting has stopped
        // zero reload holds
        halt_evt  = (reload_ff == {CNT_W{1'b0}});
      end else begin
        nxt_count = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        wrap_evt  = (count_ff == {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end else begin
      nxt_count = count_ff;
    end
  end

  // no reset on count
  // left unreset on purpose: software must clear it before enabling
  always @(posedge aclk) begin
    count_ff <= nxt_count;
  end

  // ***************************************************************
  // wrap flag
  // ***************************************************************
  reg  wrap_flag_ff;
  reg  nxt_wrap_flag;
  wire flag_rd;

  assign flag_rd = rd_en & (rsel == SEL_CTRL);

  // a wrap in the read's own cycle survives: the read saw the old flag
  always @* begin
    nxt_wrap_flag = wrap_flag_ff;
    if (wrap_evt) begin
      nxt_wrap_flag = 1'b1;
    end else if (flag_rd) begin
      nxt_wrap_flag = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag_ff <= `STDC_RST_FLAG;
    end else begin
      wrap_flag_ff <= nxt_wrap_flag;
    end
  end

  // ***************************************************************
  // interrupt status
  // ***************************************************************
  wire [`STDC_EVT_N-1:0] evt;
  wire [`STDC_EVT_N-1:0] irq_status;
  wire [`STDC_EVT_N-1:0] irq_enable;

  assign evt[`STDC_EVT_WRAP_BIT] = wrap_evt;
  assign evt[`STDC_EVT_HALT_BIT] = halt_evt;

  stdc_irq #(
    .N (`STDC_EVT_N)
  ) u_irq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .evt      (evt),
    .clr_wr   (wr_en & (wsel == SEL_ICLR)),
    .clr_data (wr_data[`STDC_EVT_N-1:0]),
    .en_wr    (wr_en & (wsel == SEL_IEN)),
    .en_data  (wr_data[`STDC_EVT_N-1:0]),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (irq)
  );

  // ***************************************************************
  // read data
  // ***************************************************************
  // the flag reads back as it stood before its own read clears it
  always @* begin
    rd_data = 32'h00000000;
    case (rsel)
      SEL_CTRL: begin
        rd_data[`STDC_CTRL_EN_BIT]   = enable_ff;
        rd_data[`STDC_CTRL_WRAP_BIT] = wrap_flag_ff;
      end
      SEL_RLD: begin
        rd_data = reload_word;
      end
      SEL_CUR: begin
        rd_data = {{(32 - CNT_W){1'b0}}, count_ff};
      end
      SEL_IST: begin
        rd_data = {{(32 - `STDC_EVT_N){1'b0}}, irq_status};
      end
      SEL_IEN: begin
        rd_data = {{(32 - `STDC_EVT_N){1'b0}}, irq_enable};
      end
      default: begin
        // clear register and holes read as zero
        rd_data = 32'h00000000;
      end
    endcase
  end

  // pins mirror the registers so they change on the clock edge only
  assign tick_current_value = count_ff;
  assign tick_wrap_flag     = wrap_flag_ff;

endmodule

/* File: test/stdc_top_sva.sv */
// checker for the count, reload and wrap flag of the tick counter
`include "stdc_regs.vh"

module stdc_top_sva #(
  parameter AW    = 8,
  parameter CNT_W = 24
) (
  input wire             aclk,
  input wire             aresetn,
  input wire [AW-1:0]    s_axi_awaddr,
  input wire             s_axi_awvalid,
  input wire [31:0]      s_axi_wdata,
  input wire [3:0]       s_axi_wstrb,
  input wire             s_axi_wvalid,
  input wire             s_axi_bvalid,
  input wire [AW-1:0]    s_axi_araddr,
  input wire             s_axi_arvalid,
  input wire             s_axi_arready,
  input wire [CNT_W-1:0] tick_current_value,
  input wire             tick_wrap_flag
);
  timeunit 1ns;
  timeprecision 1ps;

  // *****
  // reload shadow
  // *****
  reg  [AW-1:0]    aw_ff;
  reg  [31:0]      wd_ff;
  reg  [3:0]       ws_ff;
  reg              bv_ff;
  reg  [CNT_W-1:0] rld_ff;
  integer          i;
  wire [CNT_W-1:0] cnt;
  wire             flag;
  wire             rd_ctrl;

  assign cnt     = tick_current_value;
  assign flag    = tick_wrap_flag;
  assign rd_ctrl = s_axi_arvalid && s_axi_arready &&
                   s_axi_araddr == `STDC_OFS_CTRL;

  // lags the design by one edge; the halt check allows for it
  always @(posedge aclk) begin
    bv_ff <= s_axi_bvalid;
    if (s_axi_awvalid)
      aw_ff <= s_axi_awaddr;
    if (s_axi_wvalid) begin
      wd_ff <= s_axi_wdata;
      ws_ff <= s_axi_wstrb;
    end
    if (!aresetn)
      rld_ff <= `STDC_RST_RELOAD;
    else if (s_axi_bvalid && !bv_ff && aw_ff == `STDC_OFS_RELOAD)
      for (i = 0; i < CNT_W / 8; i = i + 1)
        if (ws_ff[i])
          rld_ff[8*i +: 8] <= wd_ff[8*i +: 8];
  end

  // *****
  // properties
  // *****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_CNT_STEP:
    assert property (cnt != 0 |=> cnt == 0 || cnt == $past(cnt) ||
                     cnt + 1 == $past(cnt))
    else $error("count moved by more than one");
  AST_RELOAD:
    assert property (cnt != 0 && $past(cnt) == 0 |-> cnt == rld_ff)
    else $error("count left zero without the reload value");
  AST_WRAP_SET:
    assert property ($past(cnt) == 1 && cnt == 0 && !$rose(s_axi_bvalid)
                     |-> flag)
    else $error("wrap to zero did not set the flag");
  AST_FLAG_CAUSE:
    assert property ($rose(flag) |-> $past(cnt) == 1 && cnt == 0)
    else $error("flag set without a wrap");
  AST_READ_CLR:
    assert property (rd_ctrl |=> !flag || $past(cnt) == 1 && cnt == 0)
    else $error("control read left the flag set");
  AST_FLAG_KEEP:
    assert property ($fell(flag) |-> $past(rd_ctrl))
    else $error("flag dropped without a control read");
  AST_WR_CLR:
    assert property ($rose(s_axi_bvalid) && aw_ff == `STDC_OFS_CURRENT
                     |-> cnt == 0)
    else $error("current value write did not clear the count");
  AST_HALT:
    assert property (rld_ff == 0 && cnt == 0 && !s_axi_bvalid |=> cnt == 0)
    else $error("count left zero with a zero reload");
endmodule

bind stdc_top stdc_top_sva #(.AW(AW), .CNT_W(CNT_W)) stdc_top_sva_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .tick_current_value, .tick_wrap_flag
);

/* File: test/system_tick_down_counter_test.sv */
// self-checking bench for the tick down counter
`include "stdc_regs.vh"

module system_tick_down_counter_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic [7:0]  s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq;
  logic [23:0] tick_current_value;
  logic        tick_wrap_flag;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [23:0] prev;
  logic [23:0] rl;
  int          mismatches = 0;
  int          checked = 0;

  stdc_top stdc_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tick_current_value,
    .tick_wrap_flag, .irq
  );

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `STDC_RESP_OKAY,
                    input logic [3:0] st = 4'hF);
    bit a_ok;
    bit w_ok;
    wr_q.push_back(er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    a_ok = 0;
    w_ok = 0;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        a_ok = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `STDC_RESP_OKAY);
    rd_q.push_back({er, d});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // answers are paired with the oldest note at the handshake edge
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
  end

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    repeat (4000) @(posedge aclk);
    mismatches++;
    finish_test;
  end

  // *****
  // stimulus
  // *****
  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(17357));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`STDC_OFS_CTRL, 32'h0);
    rd(`STDC_OFS_IRQ_STAT, 32'h0);
    rd(8'h18, 32'h0, `STDC_RESP_SLVERR);
    wr(8'h18, $urandom, `STDC_RESP_SLVERR);
    wr(`STDC_OFS_RELOAD, 32'hFFFFFFFF);
    rd(`STDC_OFS_RELOAD, 32'h00FFFFFF);
    wr(`STDC_OFS_RELOAD, 32'h00123456, `STDC_RESP_OKAY, 4'h2);
    rd(`STDC_OFS_RELOAD, 32'h00FF34FF);
    $display("test registers done");
    rl = 24'(2 + $urandom % 6);
    wr(`STDC_OFS_RELOAD, {8'h0, rl});
    wr(`STDC_OFS_CURRENT, $urandom);
    wr(`STDC_OFS_IRQ_EN, 32'h1);
    wr(`STDC_OFS_CTRL, 32'h1);
    prev = tick_current_value;
    repeat (3 * rl + 3) begin
      @(posedge aclk);
      check("count", tick_current_value, prev == 0 ? rl : prev - 1);
      if (prev == 1)
        check("flag", tick_wrap_flag, 1'h1);
      prev = tick_current_value;
    end
    wr(`STDC_OFS_CTRL, 32'h0);
    check("irq", irq, 1'h1);
    rd(`STDC_OFS_CTRL, 32'h0001_0000);
    rd(`STDC_OFS_CTRL, 32'h0);
    rd(`STDC_OFS_IRQ_STAT, 32'h1);
    wr(`STDC_OFS_IRQ_CLR, 32'h1);
    check("irq", irq, 1'h0);
    $display("test periodic count done");
    prev = tick_current_value;
    repeat (8) @(posedge aclk);
    check("hold", tick_current_value, prev);
    check("flag", tick_wrap_flag, 1'h0);
    rd(`STDC_OFS_CURRENT, {8'h0, prev});
    wr(`STDC_OFS_CURRENT, $urandom);
    rd(`STDC_OFS_CURRENT, 32'h0);
    $display("test hold and clear done");
    wr(`STDC_OFS_RELOAD, 32'h0);
    wr(`STDC_OFS_CTRL, 32'h1);
    repeat (5) @(posedge aclk);
    check("halt", tick_current_value, 24'h0);
    check("flag", tick_wrap_flag, 1'h0);
    check("irq", irq, 1'h0);
    wr(`STDC_OFS_CTRL, 32'h0);
    rd(`STDC_OFS_IRQ_STAT, 32'h2);
    wr(`STDC_OFS_IRQ_EN, 32'h3);
    check("irq", irq, 1'h1);
    wr(`STDC_OFS_IRQ_CLR, 32'h2);
    check("irq", irq, 1'h0);
    $display("test zero reload done");
    repeat (2) @(posedge aclk);
    finish_test;
  end
endmodule
